//--- src/lpm_pkg.sv
package lpm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFFS = 8'h04;

  // ****************************************
  // low_power_mode_control fields
  // ****************************************
  localparam int STOP_BIT  = 7;
  localparam int SLEEP_BIT = 6;
  localparam int FLOAT_BIT = 5;
  localparam int SWRST_BIT = 4;
  localparam int TMD_BIT   = 3;
  localparam int HALT_LSB  = 1;
  localparam int HALT_W    = 2;
  localparam logic              FLOAT_RST = 1'b0;
  localparam logic [HALT_W-1:0] HALT_RST  = 2'h0;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_KIND_LSB  = 3;
  localparam int ST_CPUCLK    = 5;
  localparam int ST_INTRST    = 6;
  localparam int ST_HIZ       = 7;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [1:0] SW_RESET_CYCLES = 2'h3;
  localparam int         WAKE_CYCLES     = 16;
  localparam int         HALT_CNT_W      = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // gray along run -> sleep -> timebase -> watch -> stop -> wake
  typedef enum logic [2:0] {
    MODE_RUN   = 3'h0,
    MODE_SLEEP = 3'h1,
    MODE_TBT   = 3'h3,
    MODE_WATCH = 3'h2,
    MODE_STOP  = 3'h6,
    MODE_WAKE  = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    KIND_MAIN = 2'h0,
    KIND_PLL  = 2'h1,
    KIND_SUB  = 2'h2
  } sleep_kind_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } reg_write_t;

  // suppressed cpu cycles per access, zero gives the fewest
  function automatic logic [HALT_CNT_W-1:0] haltCycles(
    input logic [HALT_W-1:0] sel
  );
    case (sel)
      2'h0:    haltCycles = 6'h00;
      2'h1:    haltCycles = 6'h08;
      2'h2:    haltCycles = 6'h10;
      default: haltCycles = 6'h20;
    endcase
  endfunction

  function automatic logic regMapped(input logic [ADDR_W-1:0] a);
    regMapped = (a == CTRL_OFFS) || (a == STAT_OFFS);
  endfunction

endpackage

//--- src/lpm_axil_slave.sv
`timescale 1ns/10ps
module lpm_axil_slave (
  input  wire logic                      core_clk,  // clock
  input  wire logic                      reset,     // async, high
  input  wire logic [lpm_pkg::ADDR_W-1:0] awaddr,   // write address
  input  wire logic                      awvalid,   // aw valid
  output logic                           awready,   // aw ready
  input  wire logic [31:0]               wdata,     // write data
  input  wire logic [3:0]                wstrb,     // byte enables
  input  wire logic                      wvalid,    // w valid
  output logic                           wready,    // w ready
  output logic [1:0]                     bresp,     // write response
  output logic                           bvalid,    // b valid
  input  wire logic                      bready,    // b ready
  input  wire logic [lpm_pkg::ADDR_W-1:0] araddr,   // read address
  input  wire logic                      arvalid,   // ar valid
  output logic                           arready,   // ar ready
  output logic [31:0]                    rdata,     // read data
  output logic [1:0]                     rresp,     // read response
  output logic                           rvalid,    // r valid
  input  wire logic                      rready,    // r ready
  output lpm_pkg::reg_write_t            regWr,     // register write
  output logic [lpm_pkg::ADDR_W-1:0]     rdAddr,    // read lookup addr
  input  wire logic [31:0]               rdWord     // read lookup data
);

  logic                       awHeld_q, awHeld_d;
  logic                       wHeld_q,  wHeld_d;
  logic [lpm_pkg::ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0]                wData_q,  wData_d;
  logic [3:0]                 wStrb_q,  wStrb_d;
  logic                       bValid_q, bValid_d;
  logic [1:0]                 bResp_q,  bResp_d;
  logic                       rValid_q, rValid_d;
  logic [1:0]                 rResp_q,  rResp_d;
  logic [31:0]                rData_q,  rData_d;
  logic                       doWrite;

  assign awready = !awHeld_q;
  assign wready  = !wHeld_q;
  assign arready = !rValid_q;
  assign bvalid  = bValid_q;
  assign bresp   = bResp_q;
  assign rvalid  = rValid_q;
  assign rresp   = rResp_q;
  assign rdata   = rData_q;
  assign rdAddr  = araddr;
  // a write commits only once the previous response has gone
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign regWr   = '{valid: doWrite && lpm_pkg::regMapped(awAddr_q),
                     addr: awAddr_q, data: wData_q, strb: wStrb_q};

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rResp_d  = rResp_q;
    rData_d  = rData_q;
    if (awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && !wHeld_q) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (bValid_q && bready) begin
      bValid_d = 1'b0;
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = lpm_pkg::regMapped(awAddr_q) ? lpm_pkg::RESP_OKAY
                                              : lpm_pkg::RESP_DECERR;
    end
    if (rValid_q && rready) begin
      rValid_d = 1'b0;
    end
    if (arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rData_d  = rdWord;
      rResp_d  = lpm_pkg::regMapped(araddr) ? lpm_pkg::RESP_OKAY
                                            : lpm_pkg::RESP_DECERR;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
      bValid_q <= 1'b0;
      bResp_q  <= lpm_pkg::RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q  <= lpm_pkg::RESP_OKAY;
      rData_q  <= '0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q  <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q  <= rResp_d;
      rData_q  <= rData_d;
    end
  end

endmodule

//--- src/low_power_mode_control.sv
// Functional notes
// RQ1 - timebase mode: only oscillators, timebase, watch timer, detector run
// RQ2 - stop mode halts main and sub oscillators; state is kept
// RQ3 - stop bit: one enters stop, zero ignored, reads zero
// RQ4 - sleep bit: one enters sleep, zero ignored, reads zero
// RQ5 - stop and sleep written together: stop wins
// RQ6 - pin float bit: hold or high-z in deep modes, resets to zero
// RQ7 - writing zero to reset bit gives three-cycle internal reset; reads one
// RQ8 - timer request zero: timebase mode on main/pll, watch on sub-clock
// RQ9 - halt select picks suppressed cycles; any reset clears it
// RQ10 - software writes zero to reserved bit zero
// RQ11 - intermittent mode withholds cpu clock after each access
// RQ12 - software waits for clock-mode change before a new request
// RQ13 - word writes requesting a mode use the even address
// RQ14 - only the listed direct-write instruction forms request a mode
// RQ15 - request write is followed by the fixed instruction sequence
// RQ16 - sleep kind follows pll and subclock selects; only cpu clock stops; the code also stops the main oscillator in sub-clock sleep
// RQ17 - software disables peripheral outputs before floating shared pins
// RQ18 - wake sources per mode: timebase, watch, stop
// RQ19 - sleep request with a pending interrupt does not enter sleep
// RQ20 - sleep kind selects come from the clock selection register
// RQ21 - halt select maps to monotonically rising cycle counts
// RQ22 - reset wake restarts oscillators, holds cpu until sequence ends
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module low_power_mode_control #(
  parameter int WAKE_CYCLES = lpm_pkg::WAKE_CYCLES  // reset sequence length
) (
  input  wire logic                       core_clk,        // machine clock
  input  wire logic                       reset,           // async, high
  input  wire logic [lpm_pkg::ADDR_W-1:0] awaddr,          // axi write addr
  input  wire logic                       awvalid,         // aw valid
  output logic                            awready,         // aw ready
  input  wire logic [31:0]                wdata,           // axi write data
  input  wire logic [3:0]                 wstrb,           // byte enables
  input  wire logic                       wvalid,          // w valid
  output logic                            wready,          // w ready
  output logic [1:0]                      bresp,           // write response
  output logic                            bvalid,          // b valid
  input  wire logic                       bready,          // b ready
  input  wire logic [lpm_pkg::ADDR_W-1:0] araddr,          // axi read addr
  input  wire logic                       arvalid,         // ar valid
  output logic                            arready,         // ar ready
  output logic [31:0]                     rdata,           // read data
  output logic [1:0]                      rresp,           // read response
  output logic                            rvalid,          // r valid
  input  wire logic                       rready,          // r ready
  input  wire logic                       pllClockSelect,  // clock sel reg
  input  wire logic                       subclockSelect,  // clock sel reg
  input  wire logic                       irqPending,      // any irq request
  input  wire logic                       extIrq,          // external irq
  input  wire logic                       watchTimerIrq,   // watch timer irq
  input  wire logic                       timebaseIrq,     // timebase irq
  input  wire logic                       extResetReq,     // external reset
  input  wire logic                       cpuAccess,       // access done pulse
  output logic                            cpuClkEn,        // cpu clock gate
  output logic                            periphClkEn,     // peripheral gate
  output logic                            mainOscRun,      // oscillation clk
  output logic                            subOscRun,       // sub-clock
  output logic                            timebaseRun,     // timebase timer
  output logic                            watchRun,        // watch timer
  output logic                            pinHiZ,          // float the pins
  output logic                            pinHold,         // latch pin levels
  output logic                            internalReset    // soft reset pulse
);

  // ****************************************
  // state
  // ****************************************
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES - 1);

  lpm_pkg::mode_t                   mode_q,     mode_d;
  logic                             pinFloat_q, pinFloat_d;
  logic [lpm_pkg::HALT_W-1:0]       haltSel_q,  haltSel_d;
  logic [lpm_pkg::HALT_CNT_W-1:0]   haltCnt_q,  haltCnt_d;
  logic [1:0]                       swRst_q,    swRst_d;
  logic [WAKE_W-1:0]                wakeCnt_q,  wakeCnt_d;
  lpm_pkg::reg_write_t              regWr;
  logic [lpm_pkg::ADDR_W-1:0]       rdAddr;
  logic [31:0]                      rdWord;
  logic                             ctrlWr;
  logic [7:0]                       wByte;
  logic                             deepMode;
  lpm_pkg::sleep_kind_t             sleepKind;

  // ****************************************
  // bus slave
  // ****************************************
  lpm_axil_slave u_slave (
    .core_clk (core_clk),
    .reset    (reset),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .regWr    (regWr),
    .rdAddr   (rdAddr),
    .rdWord   (rdWord)
  );

  assign wByte  = regWr.data[7:0];
  // the control byte lives in lane 0 only
  assign ctrlWr = regWr.valid && regWr.addr == lpm_pkg::CTRL_OFFS &&
                  regWr.strb[0];

  // ****************************************
  // sleep flavour
  // ****************************************
  always_comb begin
    if (!subclockSelect) begin
      sleepKind = lpm_pkg::KIND_SUB;                        // [RQ16] [RQ20]
    end else if (pllClockSelect) begin
      sleepKind = lpm_pkg::KIND_MAIN;                       // [RQ16] [RQ20]
    end else begin
      sleepKind = lpm_pkg::KIND_PLL;                        // [RQ16] [RQ20]
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rdWord = 32'h0;
    if (rdAddr == lpm_pkg::CTRL_OFFS) begin
      // request bits read 0, reset and timer bits read 1
      rdWord[lpm_pkg::SWRST_BIT] = 1'b1;                    // [RQ7]
      rdWord[lpm_pkg::TMD_BIT]   = 1'b1;                    // [RQ8]
      rdWord[lpm_pkg::FLOAT_BIT] = pinFloat_q;
      rdWord[lpm_pkg::HALT_LSB +: lpm_pkg::HALT_W] = haltSel_q;
    end else if (rdAddr == lpm_pkg::STAT_OFFS) begin
      rdWord[lpm_pkg::ST_MODE_LSB +: 3] = mode_q;
      rdWord[lpm_pkg::ST_KIND_LSB +: 2] = sleepKind;
      rdWord[lpm_pkg::ST_CPUCLK]        = cpuClkEn;
      rdWord[lpm_pkg::ST_INTRST]        = internalReset;
      rdWord[lpm_pkg::ST_HIZ]           = pinHiZ;
    end
  end

  // ****************************************
  // mode sequencer
  // ****************************************
  always_comb begin
    mode_d     = mode_q;
    pinFloat_d = pinFloat_q;
    haltSel_d  = haltSel_q;
    haltCnt_d  = haltCnt_q;
    swRst_d    = swRst_q;
    wakeCnt_d  = wakeCnt_q;
    if (swRst_q != 2'h0) begin
      swRst_d = swRst_q - 2'h1;
    end
    if (haltCnt_q != '0) begin
      haltCnt_d = haltCnt_q - 1'b1;                         // [RQ11]
    end
    case (mode_q)
      lpm_pkg::MODE_RUN: begin
        if (ctrlWr) begin
          pinFloat_d = wByte[lpm_pkg::FLOAT_BIT];           // [RQ6]
          haltSel_d  = wByte[lpm_pkg::HALT_LSB +: lpm_pkg::HALT_W]; // [RQ9]
          if (!wByte[lpm_pkg::SWRST_BIT]) begin
            swRst_d = lpm_pkg::SW_RESET_CYCLES;             // [RQ7]
          end
          if (wByte[lpm_pkg::STOP_BIT]) begin
            mode_d = lpm_pkg::MODE_STOP;                    // [RQ3] [RQ5]
          end else if (!wByte[lpm_pkg::TMD_BIT]) begin
            if (!irqPending) begin
              mode_d = subclockSelect ? lpm_pkg::MODE_TBT
                                      : lpm_pkg::MODE_WATCH; // [RQ8]
            end
          end else if (wByte[lpm_pkg::SLEEP_BIT] && !irqPending) begin
            mode_d = lpm_pkg::MODE_SLEEP;                   // [RQ4] [RQ19]
          end
        end else if (cpuAccess && haltCnt_q == '0) begin
          haltCnt_d = lpm_pkg::haltCycles(haltSel_q);       // [RQ11] [RQ21]
        end
      end
      lpm_pkg::MODE_SLEEP: begin
        if (irqPending) begin
          mode_d = lpm_pkg::MODE_RUN;
        end
      end
      lpm_pkg::MODE_TBT: begin
        if (watchTimerIrq || timebaseIrq || extIrq) begin
          mode_d = lpm_pkg::MODE_RUN;                       // [RQ18]
        end
      end
      lpm_pkg::MODE_WATCH: begin
        if (watchTimerIrq || extIrq) begin
          mode_d = lpm_pkg::MODE_RUN;                       // [RQ18]
        end
      end
      lpm_pkg::MODE_STOP: begin
        if (extIrq) begin
          mode_d = lpm_pkg::MODE_RUN;                       // [RQ18]
        end
      end
      lpm_pkg::MODE_WAKE: begin
        if (wakeCnt_q == '0) begin
          mode_d = lpm_pkg::MODE_RUN;                       // [RQ22]
        end else begin
          wakeCnt_d = wakeCnt_q - 1'b1;
        end
      end
      default: begin
        mode_d = lpm_pkg::MODE_RUN;
      end
    endcase
    // the soft reset is a reset too: control fields go back
    if (swRst_q != 2'h0) begin
      pinFloat_d = lpm_pkg::FLOAT_RST;                      // [RQ6]
      haltSel_d  = lpm_pkg::HALT_RST;                       // [RQ9]
      haltCnt_d  = '0;
    end
    if (extResetReq) begin
      mode_d     = lpm_pkg::MODE_WAKE;                      // [RQ22]
      wakeCnt_d  = WAKE_LOAD;
      pinFloat_d = lpm_pkg::FLOAT_RST;                      // [RQ6]
      haltSel_d  = lpm_pkg::HALT_RST;                       // [RQ9]
      haltCnt_d  = '0;
      swRst_d    = 2'h0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_q     <= lpm_pkg::MODE_RUN;
      pinFloat_q <= lpm_pkg::FLOAT_RST;
      haltSel_q  <= lpm_pkg::HALT_RST;
      haltCnt_q  <= '0;
      swRst_q    <= 2'h0;
      wakeCnt_q  <= '0;
    end else begin
      mode_q     <= mode_d;
      pinFloat_q <= pinFloat_d;
      haltSel_q  <= haltSel_d;
      haltCnt_q  <= haltCnt_d;
      swRst_q    <= swRst_d;
      wakeCnt_q  <= wakeCnt_d;
    end
  end

  // ****************************************
  // clock and pin control
  // ****************************************
  assign deepMode = mode_q == lpm_pkg::MODE_TBT ||
                    mode_q == lpm_pkg::MODE_WATCH ||
                    mode_q == lpm_pkg::MODE_STOP;
  assign internalReset = swRst_q != 2'h0;                   // [RQ7]
  // the cpu sees no edge while halted, reset or in any standby
  assign cpuClkEn    = mode_q == lpm_pkg::MODE_RUN &&
                       haltCnt_q == '0 && !internalReset;   // [RQ11] [RQ16]
  // peripherals keep full speed in run, intermittent and sleep
  assign periphClkEn = mode_q == lpm_pkg::MODE_RUN ||
                       mode_q == lpm_pkg::MODE_SLEEP ||
                       mode_q == lpm_pkg::MODE_WAKE;        // [RQ1] [RQ11]
  // oscillators restart as soon as the reset sequence begins
  assign mainOscRun  = mode_q != lpm_pkg::MODE_STOP &&
                       mode_q != lpm_pkg::MODE_WATCH &&
                       !(mode_q == lpm_pkg::MODE_SLEEP &&
                         sleepKind == lpm_pkg::KIND_SUB);   // [RQ2] [RQ22]
  assign subOscRun   = mode_q != lpm_pkg::MODE_STOP;        // [RQ2]
  assign timebaseRun = mainOscRun;                          // [RQ1]
  assign watchRun    = subOscRun;                           // [RQ1]
  assign pinHiZ      = deepMode && pinFloat_q;              // [RQ6]
  assign pinHold     = deepMode && !pinFloat_q;             // [RQ6]

endmodule

//--- verif/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
  input  wire logic core_clk,   // machine clock
  input  wire logic reset,      // async, high
  input  wire logic cpuClkEn,   // cpu clock gate
  input  wire logic go,         // issue one access
  output logic      cpuAccess   // access done pulse
);
  // ************
  // access sequencing
  // ************
  logic pend_q;
  // a request made while the clock is withheld waits
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_q    <= 1'b0;
      cpuAccess <= 1'b0;
    end else begin
      cpuAccess <= (pend_q || go) && cpuClkEn;
      pend_q    <= (pend_q || go) && !cpuClkEn;
    end
  end
endmodule

//--- verif/lpm_ctrl_props.sv
`timescale 1ns/10ps
module lpm_ctrl_props #(
  parameter int WAKE_CYCLES = 16  // reset sequence length
) (
  input logic core_clk,      // clock
  input logic reset,         // async, high
  input logic awvalid,       // aw valid
  input logic awready,       // aw ready
  input logic wvalid,        // w valid
  input logic wready,        // w ready
  input logic bvalid,        // b valid
  input logic bready,        // b ready
  input logic arvalid,       // ar valid
  input logic arready,       // ar ready
  input logic rvalid,        // r valid
  input logic extResetReq,   // external reset
  input logic extIrq,        // external irq
  input logic cpuClkEn,      // cpu clock gate
  input logic periphClkEn,   // peripheral gate
  input logic mainOscRun,    // oscillation clk
  input logic subOscRun,     // sub-clock
  input logic timebaseRun,   // timebase timer
  input logic watchRun,      // watch timer
  input logic pinHiZ,        // float the pins
  input logic pinHold,       // latch pin levels
  input logic internalReset  // soft reset pulse
);
  // ************
  // properties
  // ************
  // slack: the fall edge and the hop back to run
  localparam int WAKE_MAX = WAKE_CYCLES + 2;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_swrst_len: assert property ($rose(internalReset) |->
    internalReset [*3] ##1 !internalReset) else $error("soft reset width");
  a_stop_halts: assert property (!subOscRun |-> !mainOscRun &&
    !cpuClkEn && !periphClkEn && !timebaseRun && !watchRun)
    else $error("stop runs on");
  a_tbt_keeps: assert property (mainOscRun && !periphClkEn |->
    subOscRun && timebaseRun && watchRun && !cpuClkEn)
    else $error("timebase clocks");
  a_pins_deep: assert property (pinHiZ || pinHold |->
    !periphClkEn && !(pinHiZ && pinHold)) else $error("pin state");
  a_stop_wake: assert property (!subOscRun && !extIrq &&
    !extResetReq |=> !subOscRun) else $error("stop left early");
  a_wake_hold: assert property ($fell(extResetReq) |->
    !cpuClkEn && mainOscRun && subOscRun) else $error("wake too early");
  a_wake_ends: assert property ($fell(extResetReq) |->
    ##[1:WAKE_MAX] cpuClkEn) else $error("wake never ends");
  // commit edge follows the handshake edge, so the answer is two away
  a_b_follows: assert property (awvalid && awready && wvalid && wready
    && !bvalid |=> ##1 bvalid) else $error("b late");
  a_r_follows: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("r late");
  a_b_clears: assert property (bvalid && bready |=> !bvalid)
    else $error("b stuck");
endmodule

bind low_power_mode_control lpm_ctrl_props #(
  .WAKE_CYCLES(WAKE_CYCLES)
) u_props (.*);

//--- verif/low_power_mode_control_tb.sv
`timescale 1ns/10ps
module low_power_mode_control_tb;
  // ************
  // signals
  // ************
  localparam int          WAKE = 2;
  localparam logic [7:0]  CTRL = lpm_pkg::CTRL_OFFS;
  localparam logic [7:0]  STAT = lpm_pkg::STAT_OFFS;
  localparam logic [1:0]  OK   = lpm_pkg::RESP_OKAY;
  localparam logic [1:0]  DEC  = lpm_pkg::RESP_DECERR;
  localparam logic [5:0]  HALT_EXP [4] = '{6'h00, 6'h08, 6'h10, 6'h20};
  logic        core_clk = 1'b0, reset = 1'b1, go = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d, rdata;
  logic [3:0]  wstrb = 4'h0, wkv = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, extResetReq = 1'b0;
  logic        pllClockSelect = 1'b1, subclockSelect = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, cpuAccess;
  logic        cpuClkEn, periphClkEn, mainOscRun, subOscRun, pinHiZ;
  logic        pinHold;
  logic [1:0]  bresp, rresp, r;
  int          n_errors = 0, total_checks = 0, cycles = 0, n, pn;

  low_power_mode_control #(.WAKE_CYCLES(WAKE)) DUT (
    .*, .irqPending(wkv[0]), .extIrq(wkv[1]), .watchTimerIrq(wkv[2]),
    .timebaseIrq(wkv[3]), .timebaseRun(), .watchRun(), .internalReset());
  cpu_model CPU (.*);

  always #2 core_clk = ~core_clk;

  // ************
  // tasks
  // ************
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h got %h", nm, e, g);
    end
  endtask

  // one direct aligned store, bit0 clear, selects settled first, then idle
  task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                    input logic [3:0] s, input logic [1:0] er);
    logic aDone = 1'b0, wDone = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(posedge core_clk);
      if (!aDone && awready) begin
        awvalid <= 1'b0;
        aDone = 1'b1;
      end
      if (!wDone && wready) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, e);
    rd(a);
    chk(nm, e, d & m);
    chk("rresp", OK, r);
  endtask

  // enter a mode; a foreign source keeps it, a proper one wakes it
  task automatic modeCase(input logic pll, sub, input logic [7:0] wd,
                          input logic [2:0] em, input logic [3:0] nw, wk);
    logic deep = em != 3'h1;
    pllClockSelect <= pll;
    subclockSelect <= sub;
    wr(CTRL, {24'h0, wd}, 4'h1, OK);
    rdc("mode", STAT, 32'h7, {29'h0, em});
    if (!deep) rdc("kind", STAT, 32'h18, sub ? (pll ? 0 : 8) : 16);
    #1;
    chk("cpuclk", 0, cpuClkEn);
    chk("periph", !deep, periphClkEn);
    chk("mainosc", !(em == 6 || em == 2 || (!deep && !sub)), mainOscRun);
    chk("hiz", deep && wd[5], pinHiZ);
    chk("hold", deep && !wd[5], pinHold);
    rdc("ctrl_rd", CTRL, 32'hffffffff, {26'h0, wd[5], 5'h18});
    wkv <= nw;
    rdc("stays", STAT, 32'h7, {29'h0, em});
    wkv <= wk;
    repeat (2) @(posedge core_clk);
    wkv <= 4'h0;
    rdc("woken", STAT, 32'h7, 32'h0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // run is a few hundred cycles; this only catches a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // ************
  // tests
  // ************
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    rdc("ctrl", CTRL, 32'hffffffff, 32'h18);
    rdc("stat", STAT, 32'hffe7, 32'h20);
    wr(8'h08, 32'h0, 4'hf, DEC);
    rd(8'h08);
    chk("rresp_unmapped", DEC, r);
    $display("test reset_and_map done");
    for (int i = 0; i < 4; i++) begin
      wr(CTRL, 32'h18 | 32'(i * 2), 4'h1, OK);
      rdc("halt_sel", CTRL, 32'hff, 32'h18 | 32'(i * 2));
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      n = 0;
      pn = 0;
      repeat (40) begin
        @(posedge core_clk);
        n += !cpuClkEn;
        pn += !periphClkEn;
      end
      chk("halt_cycles", HALT_EXP[i], n);
      chk("periph_full", 0, pn);
    end
    $display("test intermittent done");
    wr(CTRL, 32'h3e, 4'h1, OK);
    wr(CTRL, 32'h2e, 4'h1, OK);
    rdc("after_swrst", CTRL, 32'hffffffff, 32'h18);
    $display("test soft_reset done");
    wkv <= 4'h1;
    wr(CTRL, 32'h58, 4'h1, OK);
    wr(CTRL, 32'h10, 4'h1, OK);
    wr(CTRL, 32'hd8, 4'h0, OK);
    rdc("refused", STAT, 32'h7, 32'h0);
    wkv <= 4'h0;
    $display("test refusals done");
    modeCase(1, 1, 8'h58, 3'h1, 4'h0, 4'h1);
    modeCase(0, 1, 8'h58, 3'h1, 4'h0, 4'h1);
    modeCase(1, 0, 8'h58, 3'h1, 4'h0, 4'h1);
    modeCase(1, 1, 8'hd8, 3'h6, 4'hd, 4'h2);
    modeCase(0, 1, 8'hb8, 3'h6, 4'hd, 4'h2);
    modeCase(1, 1, 8'h50, 3'h3, 4'h1, 4'h8);
    modeCase(0, 1, 8'h10, 3'h3, 4'h1, 4'h4);
    modeCase(1, 0, 8'h30, 3'h2, 4'h9, 4'h4);
    $display("test standby_modes done");
    wr(CTRL, 32'hbe, 4'h1, OK);
    @(posedge core_clk);
    extResetReq <= 1'b1;
    @(posedge core_clk);
    extResetReq <= 1'b0;
    repeat (WAKE + 4) @(posedge core_clk);
    rdc("stat_wake", STAT, 32'hffe7, 32'h20);
    rdc("ctrl_wake", CTRL, 32'hffffffff, 32'h18);
    $display("test ext_reset done");
    summarize();
  end
endmodule
